// *** core/srt_pkg.sv ***
package srt_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RAMP_UNIT_NS = 2_000_000;
  localparam int RAMP_SPAN_RPM = 1000;
  localparam int RAMP_CYC_PER_COUNT =
    RAMP_UNIT_NS / (RAMP_SPAN_RPM * CLK_PERIOD_NS);
  localparam int SCURVE_UNIT_NS = 2_000_000;
  localparam int SCURVE_TICK_CYC = SCURVE_UNIT_NS / CLK_PERIOD_NS;

  // Ranges and reset values
  localparam logic [12:0] RAMP_MAX = 13'h1388;
  localparam logic [12:0] RAMP_RESET = 13'h0000;
  localparam logic [8:0] SCURVE_MAX = 9'h1F4;
  localparam logic [8:0] SCURVE_RESET = 9'h000;
  localparam logic [8:0] TORQUE_RESET = 9'h1F4;
  localparam logic [8:0] SYS_MAX_PCT = 9'h12C;
  localparam logic [15:0] TORQUE_SCALE = 16'h000A;
  localparam logic [8:0] HIST_LAST = 9'h1FF;
  localparam int HIST_DEPTH = 512;

  // Register byte offsets
  localparam logic [5:0] OFF_ACCEL = 6'h00;
  localparam logic [5:0] OFF_DECEL = 6'h04;
  localparam logic [5:0] OFF_SCURVE = 6'h08;
  localparam logic [5:0] OFF_TQ1 = 6'h0C;
  localparam logic [5:0] OFF_TQ2 = 6'h10;
  localparam logic [5:0] OFF_SELECT = 6'h14;
  localparam logic [5:0] OFF_STATUS = 6'h18;
  localparam logic [5:0] OFF_APPLIED = 6'h1C;
  localparam logic [5:0] OFF_SYSMAX = 6'h20;
  localparam logic [5:0] OFF_SPEED = 6'h24;

  // Status bits, and the select bit of the applied register
  localparam int STAT_RAMPING = 0;
  localparam int STAT_CLAMPED = 1;
  localparam int STAT_REJECT = 2;
  localparam int STAT_FILLING = 3;
  localparam int APPLIED_SEL = 9;

  typedef enum logic [1:0] {
    SRT_FILL = 2'h0,
    SRT_RUN = 2'h1,
    SRT_DIV = 2'h3
  } srt_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } srt_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } srt_avs_rsp_t;

  typedef struct packed {
    srt_state_t st;
    logic [8:0] fill_idx;
    logic wreq;
    logic [31:0] rdata;
    logic [12:0] accel;
    logic [12:0] decel;
    logic [8:0] scurve_pend;
    logic [8:0] scurve_act;
    logic [8:0] tq1;
    logic [8:0] tq2;
    logic sel_pend;
    logic sel_act;
    logic reject;
    logic [17:0] ramp_cnt;
    logic signed [15:0] lin;
    logic [15:0] tick_cnt;
    logic [8:0] wp;
    logic signed [25:0] sum;
    logic neg;
    logic signed [15:0] speed_out;
    logic signed [15:0] torque_out;
    logic clamped;
  } srt_main_t;

  typedef struct packed {
    logic [9:0] rem;
    logic [24:0] quo;
    logic [8:0] dvs;
    logic [4:0] cnt;
    logic busy;
    logic done;
  } srt_div_t;

endpackage : srt_pkg

// *** core/srt_div.sv ***
module srt_div (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic [24:0] dividend_in,
  input wire logic [8:0] divisor_in,
  output logic [15:0] quotient_out,
  output logic done_out
);

  srt_pkg::srt_div_t r;
  srt_pkg::srt_div_t n;
  logic [9:0] rem_sh;

  // One quotient bit per clock; 25 clocks fit easily inside a 2 ms tick
  always_comb begin
    n = r;
    rem_sh = {r.rem[8:0], r.quo[24]};
    n.done = 1'b0;
    if (start_in) begin
      n.rem = '0;
      n.quo = dividend_in;
      n.dvs = divisor_in;
      n.cnt = '0;
      n.busy = 1'b1;
    end else if (r.busy) begin
      n.quo = {r.quo[23:0], 1'b0};
      if (rem_sh >= {1'b0, r.dvs}) begin
        n.rem = rem_sh - {1'b0, r.dvs};
        n.quo[0] = 1'b1;
      end else begin
        n.rem = rem_sh;
      end
      n.cnt = r.cnt + 5'h01;
      if (r.cnt == 5'h18) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign quotient_out = r.quo[15:0];
  assign done_out = r.done;

endmodule : srt_div

// *** core/srt_speed_ramp_torque_clamp.sv ***
// Implementation choices: the Avalon-MM interface to the registers and the address map.
module srt_speed_ramp_torque_clamp #(
  parameter logic [15:0] SCURVE_TICK_CYC =
    16'(srt_pkg::SCURVE_TICK_CYC)
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire srt_pkg::srt_avs_req_t avs_req_in,
  output srt_pkg::srt_avs_rsp_t avs_rsp_out,
  input wire logic ctrl_power_up_in,
  input wire logic signed [15:0] speed_cmd_in,
  input wire logic signed [15:0] torque_cmd_in,
  output logic signed [15:0] speed_ref_out,
  output logic signed [15:0] torque_out,
  output logic torque_clamped_out
);

  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  function automatic logic [17:0] ramp_limit(input logic [12:0] rate);
    return 18'(18'(rate) * 18'(srt_pkg::RAMP_CYC_PER_COUNT) - 18'h00001);
  endfunction : ramp_limit

  srt_pkg::srt_main_t r;
  srt_pkg::srt_main_t n;

  // History of ramp samples for the moving-average rounding
  logic signed [15:0] hist_mem [0:srt_pkg::HIST_DEPTH-1];
  logic mem_we;
  logic [8:0] mem_addr;
  logic signed [15:0] mem_data;
  logic signed [15:0] hist_old;

  logic div_start;
  logic [24:0] div_dividend;
  logic [15:0] div_q;
  logic div_done;

  logic up;
  logic away;
  logic [12:0] rate;
  logic tick;
  logic signed [25:0] sum_new;
  logic [8:0] lim_pct;
  logic [8:0] eff_pct;
  logic signed [15:0] lim;
  logic access;
  logic commit;
  logic [31:0] rd_val;
  logic [31:0] wv;
  logic reject_set;
  logic reject_clr;

  srt_div u_div (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .start_in(div_start),
    .dividend_in(div_dividend),
    .divisor_in(r.scurve_act),
    .quotient_out(div_q),
    .done_out(div_done)
  );

  always_comb begin
    n = r;
    mem_we = 1'b0;
    mem_addr = r.wp;
    mem_data = r.lin;
    div_start = 1'b0;
    div_dividend = '0;
    sum_new = r.sum;
    reject_set = 1'b0;
    reject_clr = 1'b0;
    wv = '0;
    rd_val = '0;
    hist_old = hist_mem[9'(r.wp - r.scurve_act)];

    // Linear ramp toward the command; accel when moving away from zero
    up = speed_cmd_in > r.lin;
    away = up ? (r.lin >= 16'sh0000) : (r.lin <= 16'sh0000);
    rate = away ? r.accel : r.decel;
    if (r.lin != speed_cmd_in) begin
      if (rate == 13'h0000) begin
        n.lin = speed_cmd_in;
        n.ramp_cnt = '0;
      end else if (r.ramp_cnt >= ramp_limit(rate)) begin
        // One r/min per rate*2 us gives rate*2 ms per 1000 r/min
        n.lin = up ? r.lin + 16'sh0001 : r.lin - 16'sh0001;
        n.ramp_cnt = '0;
      end else begin
        n.ramp_cnt = r.ramp_cnt + 18'h00001;
      end
    end else begin
      n.ramp_cnt = '0;
    end

    // 2 ms sampling tick for the rounding filter
    tick = r.tick_cnt == SCURVE_TICK_CYC - 16'h0001;
    n.tick_cnt = tick ? 16'h0000 : r.tick_cnt + 16'h0001;

    // A moving average of width ts over the linear ramp bends each
    // corner into a quasi-sigmoid spanning ts/2 either side of it
    case (r.st)
      srt_pkg::SRT_FILL: begin
        mem_we = 1'b1;
        mem_addr = r.fill_idx;
        n.fill_idx = r.fill_idx + 9'h001;
        n.speed_out = r.lin;
        if (r.fill_idx == srt_pkg::HIST_LAST) begin
          n.sum = 26'(r.lin) * 26'(signed'({1'b0, r.scurve_act}));
          n.wp = '0;
          n.st = srt_pkg::SRT_RUN;
        end
      end
      srt_pkg::SRT_RUN: begin
        if (r.scurve_act == 9'h000) begin
          n.speed_out = r.lin;
        end else if (tick) begin
          sum_new = r.sum + 26'(r.lin) - 26'(hist_old);
          n.sum = sum_new;
          mem_we = 1'b1;
          n.wp = r.wp + 9'h001;
          n.neg = sum_new[25];
          div_start = 1'b1;
          div_dividend = sum_new[25] ? 25'(-sum_new) : 25'(sum_new);
          n.st = srt_pkg::SRT_DIV;
        end
      end
      srt_pkg::SRT_DIV: begin
        if (div_done) begin
          n.speed_out = r.neg ? -signed'(div_q) : signed'(div_q);
          n.st = srt_pkg::SRT_RUN;
        end
      end
      default: begin
        n.st = srt_pkg::SRT_FILL;
        n.fill_idx = '0;
      end
    endcase

    // Window and select are power-cycle settings; history is refilled
    // so the new window starts from a settled sum
    if (ctrl_power_up_in) begin
      n.scurve_act = r.scurve_pend;
      n.sel_act = r.sel_pend;
      n.st = srt_pkg::SRT_FILL;
      n.fill_idx = '0;
    end

    // Torque clamp in units of 0.1 percent of rated
    lim_pct = r.sel_act ? r.tq2 : r.tq1;
    // The reset ceiling of 500 is above the system maximum, so the
    // system maximum governs until software lowers it
    eff_pct = (lim_pct > srt_pkg::SYS_MAX_PCT) ?
      srt_pkg::SYS_MAX_PCT : lim_pct;
    lim = signed'(16'(16'(eff_pct) * srt_pkg::TORQUE_SCALE));
    if (torque_cmd_in > lim) begin
      n.torque_out = lim;
      n.clamped = 1'b1;
    end else if (torque_cmd_in < -lim) begin
      n.torque_out = -lim;
      n.clamped = 1'b1;
    end else begin
      n.torque_out = torque_cmd_in;
      n.clamped = 1'b0;
    end

    // Read mux
    case (avs_req_in.address)
      srt_pkg::OFF_ACCEL: rd_val = 32'(r.accel);
      srt_pkg::OFF_DECEL: rd_val = 32'(r.decel);
      srt_pkg::OFF_SCURVE: rd_val = 32'(r.scurve_pend);
      srt_pkg::OFF_TQ1: rd_val = 32'(r.tq1);
      srt_pkg::OFF_TQ2: rd_val = 32'(r.tq2);
      srt_pkg::OFF_SELECT: rd_val = 32'(r.sel_pend);
      srt_pkg::OFF_STATUS: begin
        rd_val[srt_pkg::STAT_RAMPING] = r.lin != speed_cmd_in;
        rd_val[srt_pkg::STAT_CLAMPED] = r.clamped;
        rd_val[srt_pkg::STAT_REJECT] = r.reject;
        rd_val[srt_pkg::STAT_FILLING] = r.st == srt_pkg::SRT_FILL;
      end
      srt_pkg::OFF_APPLIED: begin
        rd_val[8:0] = r.scurve_act;
        rd_val[srt_pkg::APPLIED_SEL] = r.sel_act;
      end
      srt_pkg::OFF_SYSMAX: rd_val = 32'(srt_pkg::SYS_MAX_PCT);
      srt_pkg::OFF_SPEED: rd_val = {r.speed_out, r.lin};
      default: rd_val = '0;
    endcase

    // Avalon handshake: one wait cycle, then a one-cycle acknowledge
    access = avs_req_in.read | avs_req_in.write;
    if (r.wreq) begin
      if (access) begin
        n.wreq = 1'b0;
        n.rdata = rd_val;
      end
    end else begin
      n.wreq = 1'b1;
    end
    commit = avs_req_in.write & ~r.wreq;

    if (commit) begin
      wv = be_merge(rd_val, avs_req_in.writedata, avs_req_in.byteenable);
      case (avs_req_in.address)
        srt_pkg::OFF_ACCEL: begin
          if (wv > 32'(srt_pkg::RAMP_MAX)) begin
            reject_set = 1'b1;
          end else begin
            n.accel = wv[12:0];
          end
        end
        srt_pkg::OFF_DECEL: begin
          if (wv > 32'(srt_pkg::RAMP_MAX)) begin
            reject_set = 1'b1;
          end else begin
            n.decel = wv[12:0];
          end
        end
        srt_pkg::OFF_SCURVE: begin
          if (wv > 32'(srt_pkg::SCURVE_MAX)) begin
            reject_set = 1'b1;
          end else begin
            n.scurve_pend = wv[8:0];
          end
        end
        srt_pkg::OFF_TQ1: begin
          if (wv > 32'(srt_pkg::SYS_MAX_PCT)) begin
            reject_set = 1'b1;
          end else begin
            n.tq1 = wv[8:0];
          end
        end
        srt_pkg::OFF_TQ2: begin
          if (wv > 32'(srt_pkg::SYS_MAX_PCT)) begin
            reject_set = 1'b1;
          end else begin
            n.tq2 = wv[8:0];
          end
        end
        srt_pkg::OFF_SELECT: n.sel_pend = wv[0];
        srt_pkg::OFF_STATUS: reject_clr = wv[srt_pkg::STAT_REJECT];
        default: ;
      endcase
    end
    // A refusal in the same cycle as a clear keeps the flag set
    n.reject = (r.reject & ~reject_clr) | reject_set;
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      r <= '0;
      r.st <= srt_pkg::SRT_FILL;
      r.wreq <= 1'b1;
      r.accel <= srt_pkg::RAMP_RESET;
      r.decel <= srt_pkg::RAMP_RESET;
      r.scurve_pend <= srt_pkg::SCURVE_RESET;
      r.scurve_act <= srt_pkg::SCURVE_RESET;
      r.tq1 <= srt_pkg::TORQUE_RESET;
      r.tq2 <= srt_pkg::TORQUE_RESET;
    end else begin
      r <= n;
    end
  end

  // History memory needs no reset: the fill state rewrites it all
  always_ff @(posedge mclk_in) begin
    if (mem_we) begin
      hist_mem[mem_addr] <= mem_data;
    end
  end

  assign avs_rsp_out = '{readdata: r.rdata, waitrequest: r.wreq};
  assign speed_ref_out = r.speed_out;
  assign torque_out = r.torque_out;
  assign torque_clamped_out = r.clamped;

endmodule : srt_speed_ramp_torque_clamp

// *** verif/srt_far_model.sv ***
module srt_far_model (
  input wire logic mclk_in,
  input wire logic signed [15:0] torque_out_in,
  output logic signed [15:0] speed_cmd_out,
  output logic signed [15:0] torque_cmd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic signed [15:0] torque_seen_reg;
  initial begin
    speed_cmd_out = 16'h0000;
    torque_cmd_out = 16'h0000;
  end
  // Torque loop takes the clamped demand every cycle
  always_ff @(posedge mclk_in) begin
    torque_seen_reg <= torque_out_in;
  end
  // Source steps both commands right after an edge
  task automatic send(input logic signed [15:0] s, t);
    @(posedge mclk_in);
    speed_cmd_out <= s;
    torque_cmd_out <= t;
  endtask : send
endmodule : srt_far_model

// *** verif/srt_chk.sv ***
module srt_chk (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire srt_pkg::srt_avs_req_t avs_req_in,
  input wire srt_pkg::srt_avs_rsp_t avs_rsp_out,
  input wire logic ctrl_power_up_in,
  input wire logic signed [15:0] speed_cmd_in,
  input wire logic signed [15:0] torque_cmd_in,
  input wire logic signed [15:0] speed_ref_out,
  input wire logic signed [15:0] torque_out,
  input wire logic torque_clamped_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  logic [12:0] acc_reg;
  logic [12:0] dec_reg;
  logic [8:0] wpend_reg;
  logic [8:0] wact_reg;
  logic [2:0] calm_reg;
  logic wr_ok;
  logic zero;
  logic slow;
  // Shadow assumes full-word writes; lane merges are not mirrored
  assign wr_ok = avs_req_in.write && !avs_rsp_out.waitrequest &&
    avs_req_in.byteenable == 4'hF;
  assign zero = acc_reg == 13'h0000 && dec_reg == 13'h0000 &&
    wact_reg == 9'h000;
  assign slow = acc_reg != 13'h0000 && dec_reg != 13'h0000 &&
    wact_reg == 9'h000;
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      acc_reg <= 13'h0000;
      dec_reg <= 13'h0000;
      wpend_reg <= 9'h000;
      wact_reg <= 9'h000;
      calm_reg <= 3'h0;
    end else begin
      if (wr_ok && avs_req_in.writedata <= 32'h1388) begin
        if (avs_req_in.address == srt_pkg::OFF_ACCEL) begin
          acc_reg <= avs_req_in.writedata[12:0];
        end
        if (avs_req_in.address == srt_pkg::OFF_DECEL) begin
          dec_reg <= avs_req_in.writedata[12:0];
        end
      end
      if (wr_ok && avs_req_in.address == srt_pkg::OFF_SCURVE &&
          avs_req_in.writedata <= 32'h1F4) begin
        wpend_reg <= avs_req_in.writedata[8:0];
      end
      if (ctrl_power_up_in) begin
        wact_reg <= wpend_reg;
      end
      // Settle time so pipeline leftovers of an old setting are skipped
      if (wr_ok || ctrl_power_up_in) begin
        calm_reg <= 3'h0;
      end else if (calm_reg != 3'h7) begin
        calm_reg <= calm_reg + 3'h1;
      end
    end
  end
  AST_BUS_WAIT: assert property ((avs_req_in.read || avs_req_in.write) &&
    avs_rsp_out.waitrequest |=> !avs_rsp_out.waitrequest)
    else $error("bus answer late");
  AST_BUS_ACK: assert property (!avs_rsp_out.waitrequest |=>
    avs_rsp_out.waitrequest) else $error("ack longer than one cycle");
  AST_BUS_IDLE: assert property (!avs_req_in.read && !avs_req_in.write &&
    avs_rsp_out.waitrequest |=> avs_rsp_out.waitrequest)
    else $error("ack without request");
  AST_TQ_SYSMAX: assert property (torque_out <= 16'sh0BB8 &&
    torque_out >= -16'sh0BB8) else $error("torque beyond system max");
  AST_TQ_MAG: assert property ($past(torque_cmd_in) >= 0 |->
    torque_out >= 0 && torque_out <= $past(torque_cmd_in))
    else $error("positive torque not bounded");
  AST_TQ_NEG: assert property ($past(torque_cmd_in) < 0 |->
    torque_out <= 0 && torque_out >= $past(torque_cmd_in))
    else $error("negative torque not bounded");
  // Flag and clamped value come from the same sampled demand
  AST_CLAMP: assert property (torque_clamped_out |->
    torque_out != $past(torque_cmd_in))
    else $error("clamp flag without clamping");
  AST_BYPASS: assert property (zero && calm_reg == 3'h7 |->
    speed_ref_out == $past(speed_cmd_in, 2))
    else $error("zero ramp not passed through");
  AST_SLEW: assert property (slow && calm_reg == 3'h7 |->
    speed_ref_out - $past(speed_ref_out) inside {-1, 0, 1})
    else $error("ramp step too large");
  AST_HOLD: assert property (slow && calm_reg == 3'h7 &&
    $changed(speed_ref_out) |=> $stable(speed_ref_out) [*8])
    else $error("ramp moves too often");
endmodule : srt_chk

bind srt_speed_ramp_torque_clamp srt_chk u_chk (.mclk_in, .resetn_in,
  .avs_req_in, .avs_rsp_out, .ctrl_power_up_in, .speed_cmd_in,
  .torque_cmd_in, .speed_ref_out, .torque_out, .torque_clamped_out);

// *** verif/srt_speed_ramp_torque_clamp_tb.sv ***
module srt_speed_ramp_torque_clamp_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic pwr = 1'b0;
  srt_pkg::srt_avs_req_t req = '0;
  srt_pkg::srt_avs_rsp_t rsp;
  logic signed [15:0] spd;
  logic signed [15:0] tq;
  logic signed [15:0] sref;
  logic signed [15:0] tout;
  logic clmp;
  logic [31:0] rdv;
  int err_total = 0;
  int total_checks = 0;
  always #25 mclk_in = ~mclk_in;
  srt_far_model u_far (.mclk_in(mclk_in), .torque_out_in(tout),
    .speed_cmd_out(spd), .torque_cmd_out(tq));
  // Short rounding tick keeps the run small
  srt_speed_ramp_torque_clamp #(.SCURVE_TICK_CYC(16'h0028)) dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .avs_req_in(req),
    .avs_rsp_out(rsp), .ctrl_power_up_in(pwr), .speed_cmd_in(spd),
    .torque_cmd_in(tq), .speed_ref_out(sref), .torque_out(tout),
    .torque_clamped_out(clmp));
  task automatic end_sim();
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc
  // Called right after an edge; holds the request until ack is sampled
  task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'hF;
    // The wait is checked to take exactly two edges; only the watchdog ends a hung wait
    do begin
      @(posedge mclk_in);
      n++;
    end while (rsp.waitrequest !== 1'b0);
    rdv = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    chk(32'(n), 32'h2);
    @(posedge mclk_in);
  endtask : bus
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask : rdc
  task automatic power_up();
    pwr <= 1'b1;
    @(posedge mclk_in);
    pwr <= 1'b0;
  endtask : power_up
  task automatic t_reset();
    rdc(srt_pkg::OFF_ACCEL, 32'h0);
    rdc(srt_pkg::OFF_DECEL, 32'h0);
    rdc(srt_pkg::OFF_TQ1, 32'h1F4);
    rdc(srt_pkg::OFF_TQ2, 32'h1F4);
    rdc(srt_pkg::OFF_SYSMAX, 32'h12C);
    bus(1'b1, 6'h28, 32'h5);
    rdc(6'h28, 32'h0);
  endtask : t_reset
  task automatic t_torque();
    u_far.send(16'h0000, 16'h0FA0);
    cyc(3);
    chk(32'(tout), 32'(srt_pkg::SYS_MAX_PCT * srt_pkg::TORQUE_SCALE));
    chk({31'h0, clmp}, 32'h1);
    bus(1'b1, srt_pkg::OFF_TQ1, 32'h12D);
    rdc(srt_pkg::OFF_TQ1, 32'h1F4);
    bus(1'b0, srt_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, rdv[srt_pkg::STAT_REJECT]}, 32'h1);
    bus(1'b1, srt_pkg::OFF_STATUS, 32'h4);
    bus(1'b0, srt_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, rdv[srt_pkg::STAT_REJECT]}, 32'h0);
    bus(1'b1, srt_pkg::OFF_TQ1, 32'h96);
    u_far.send(16'h0000, 16'h07D0);
    cyc(3);
    chk(32'(tout), 32'h5DC);
    u_far.send(16'h0000, -16'sh07D0);
    cyc(3);
    chk(32'(tout), 32'hFFFFFA24);
    u_far.send(16'h0000, 16'h03E8);
    cyc(3);
    chk(32'(tout), 32'h3E8);
    chk({31'h0, clmp}, 32'h0);
    chk(32'(u_far.torque_seen_reg), 32'h3E8);
    bus(1'b1, srt_pkg::OFF_TQ2, 32'h64);
    bus(1'b1, srt_pkg::OFF_SELECT, 32'h1);
    u_far.send(16'h0000, 16'h07D0);
    cyc(3);
    chk(32'(tout), 32'h5DC);
    power_up();
    cyc(3);
    chk(32'(tout), 32'h3E8);
  endtask : t_torque
  task automatic t_ramp();
    u_far.send(16'h012C, 16'h0000);
    cyc(4);
    chk(32'(sref), 32'h12C);
    u_far.send(16'h0000, 16'h0000);
    cyc(4);
    bus(1'b1, srt_pkg::OFF_ACCEL, 32'h1);
    bus(1'b1, srt_pkg::OFF_DECEL, 32'h2);
    u_far.send(16'h0005, 16'h0000);
    cyc(100);
    chk({31'h0, sref inside {16'sh2, 16'sh3}}, 32'h1);
    cyc(150);
    chk(32'(sref), 32'h5);
    u_far.send(16'h0000, 16'h0000);
    cyc(200);
    // Decel twice as slow as accel, so two or three steps down
    chk({31'h0, sref inside {16'sh2, 16'sh3}}, 32'h1);
    bus(1'b1, srt_pkg::OFF_ACCEL, 32'h0);
    bus(1'b1, srt_pkg::OFF_DECEL, 32'h0);
  endtask : t_ramp
  task automatic t_window();
    bus(1'b1, srt_pkg::OFF_SCURVE, 32'h1F5);
    rdc(srt_pkg::OFF_SCURVE, 32'h0);
    // Ramps are zero here, so the window-versus-ramp limit is moot
    bus(1'b1, srt_pkg::OFF_SCURVE, 32'h4);
    rdc(srt_pkg::OFF_APPLIED, 32'h200);
    power_up();
    rdc(srt_pkg::OFF_APPLIED, 32'h204);
    cyc(600);
    u_far.send(16'h0320, 16'h0000);
    cyc(70);
    chk({31'h0, sref inside {16'sh0C8, 16'sh190}}, 32'h1);
    cyc(200);
    chk(32'(sref), 32'h320);
  endtask : t_window
  initial begin
    cyc(6);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    t_reset();
    t_torque();
    t_ramp();
    t_window();
    end_sim();
  end
  initial begin
    cyc(20000);
    err_total++;
    end_sim();
  end
endmodule : srt_speed_ramp_torque_clamp_tb
